// ===== common/sldrv_pkg.sv
// Package for the serial-in latched driver controller.
// Assumes a single core clock domain; all inputs synchronous to it.
package sldrv_pkg;

    // ------------------------------------------------------------
    // Geometry and reset values
    // ------------------------------------------------------------
    localparam int SLDRV_STAGES = 20;
    localparam int SLDRV_FIFO_DEPTH = 4;
    localparam logic [SLDRV_STAGES-1:0] SLDRV_ZERO = 20'h00000;

    // ------------------------------------------------------------
    // Serial input word carried through the FIFO
    // ------------------------------------------------------------
    typedef struct packed {
        logic data;
        logic load;
        logic blank;
    } sldrv_pin_t;

    localparam int SLDRV_PIN_W = $bits(sldrv_pin_t);
    localparam sldrv_pin_t SLDRV_PIN_IDLE = '{data: 1'b0, load: 1'b0, blank: 1'b0};

    // Driver stages of all outputs, one bit each: source on, or sink (pull-down) on
    typedef struct packed {
        logic [SLDRV_STAGES-1:0] source_on;
        logic [SLDRV_STAGES-1:0] sink_on;
    } sldrv_drive_t;

endpackage : sldrv_pkg

// ===== design/sldrv_core.sv
// Serial-in, latched, blankable output driver logic, with input FIFO.
// Assumes shift_clk, ser_data, latch_load and blank are synchronous to
// core_clk; a rising edge of shift_clk is detected in core_clk.

// ----------------------------------------------------------------
// Small FIFO
// ----------------------------------------------------------------
module sldrv_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH-1);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Words are not reset: out_data is only used while out_valid is high.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction : bump

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    wire push = in_valid && in_ready && clk_en;
    wire pop = out_valid && out_ready && clk_en;
    wire [AW-1:0] next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    wire [AW-1:0] next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign in_ready = (count != CNT_MAX);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and fill count
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ptr <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : sldrv_fifo

// ----------------------------------------------------------------
// Driver core
// ----------------------------------------------------------------
module sldrv_core
    import sldrv_pkg::*;
#(
    parameter int STAGES = SLDRV_STAGES,
    parameter int FIFO_DEPTH = SLDRV_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic shift_clk,
    input wire logic ser_data,
    input wire logic latch_load,
    input wire logic blank,
    output logic ser_out,
    output logic [STAGES-1:0] source_on,
    output logic [STAGES-1:0] sink_on,
    output logic [STAGES-1:0] latch_q
);
    // ------------------------------------------------------------
    // Serial clock edge detect; pins sampled with the clock state
    // ------------------------------------------------------------
    logic shift_clk_d;
    wire sclk_rise = shift_clk && !shift_clk_d;

    sldrv_pin_t pin_in;
    sldrv_pin_t pin_out;
    logic pin_valid;
    logic pin_ready;

    // Each rising serial clock edge becomes one FIFO word; only edges
    // with in_valid count, so the host may pace entry by in_ready.
    assign pin_in = '{data: ser_data, load: latch_load, blank: blank};

    // The drain side stalls only when clock enable is low; the fill side is gated
    // the same way, so a freeze never backs up and in_ready stays high.
    assign pin_ready = clk_en;

    // ------------------------------------------------------------
    // Input FIFO
    // ------------------------------------------------------------
    sldrv_fifo #(
        .WIDTH(SLDRV_PIN_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .in_valid(in_valid && sclk_rise),
        .in_ready(in_ready),
        .in_data(pin_in),
        .out_valid(pin_valid),
        .out_ready(pin_ready),
        .out_data(pin_out)
    );

    wire shift_step = pin_valid && pin_ready;

    // ------------------------------------------------------------
    // Serial clock history
    // ------------------------------------------------------------
    // Frozen with all other state, so a rise that spans a freeze is
    // still seen once when the clock enable returns.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_clk_d <= 1'b0;
        end else if (clk_en) begin
            shift_clk_d <= shift_clk;
        end
    end

    // ------------------------------------------------------------
    // Shift register and cascade output
    // ------------------------------------------------------------
    logic [STAGES-1:0] shreg;
    wire [STAGES-1:0] next_shreg = {shreg[STAGES-2:0], pin_out.data};
    // Taken from the stage that feeds the last one, so the cascade bit
    // equals the new last stage without a further cycle of delay.
    wire next_ser_out = shreg[STAGES-2];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shreg <= SLDRV_ZERO;
            ser_out <= 1'b0;
        end else if (shift_step) begin
            shreg <= next_shreg;
            ser_out <= next_ser_out;
        end
    end

    // ------------------------------------------------------------
    // Latch bank
    // ------------------------------------------------------------
    // Transparent latch modelled in the clock domain: follows the
    // register whenever load and clk_en are high, one cycle behind a shift.
    wire [STAGES-1:0] next_latch = latch_load ? shreg : latch_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            latch_q <= SLDRV_ZERO;
        end else if (clk_en) begin
            latch_q <= next_latch;
        end
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    // Registered so the pins never glitch while blank and latches move;
    // the price is one cycle from blank to the pins. Blank gates the
    // drivers only, latch_q is untouched by it.
    localparam sldrv_drive_t DRIVE_BLANKED = '{source_on: SLDRV_ZERO, sink_on: ~SLDRV_ZERO};

    sldrv_drive_t drive_q;
    sldrv_drive_t next_drive;

    assign next_drive = blank ? DRIVE_BLANKED :
        sldrv_drive_t'{source_on: next_latch, sink_on: ~next_latch};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= DRIVE_BLANKED;
        end else if (clk_en) begin
            drive_q <= next_drive;
        end
    end

    assign source_on = drive_q.source_on;
    assign sink_on = drive_q.sink_on;

endmodule : sldrv_core

// ===== dv/sldrv_chk.sv
// Port checker for sldrv_core.
// Assumes the host leaves the input FIFO empty between serial clock rises.
module sldrv_chk #(parameter int STAGES = 20) (
    input wire logic core_clk, rstn, clk_en, in_valid, in_ready, shift_clk,
    input wire logic ser_data, latch_load, blank, ser_out,
    input wire logic [STAGES-1:0] source_on, sink_on, latch_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_blank_forces: assert property (blank && clk_en |=>
        source_on == '0 && sink_on == '1)
        else $error("blank did not force sinks on");
    a_drive_follow: assert property (!blank && clk_en |=>
        source_on == latch_q && sink_on == ~latch_q)
        else $error("outputs differ from latches");
    a_drive_exclusive: assert property ((source_on & sink_on) == '0)
        else $error("source and sink both on");
    a_latch_hold: assert property (!latch_load |=> $stable(latch_q))
        else $error("latch changed while closed");
    a_latch_tail: assert property (latch_load && clk_en |=>
        latch_q[STAGES-1] == $past(ser_out))
        else $error("open latch not tracking register");
    a_freeze_all: assert property (!clk_en |=>
        $stable(latch_q) && $stable(ser_out) && $stable(source_on))
        else $error("state moved while frozen");
    a_ser_quiet: assert property (!shift_clk [*4] |=> $stable(ser_out))
        else $error("serial out moved without a rise");
    a_idle_ready: assert property (!shift_clk [*4] |-> in_ready)
        else $error("FIFO not ready when idle");
endmodule : sldrv_chk
bind sldrv_core sldrv_chk #(.STAGES(STAGES)) chk (.core_clk, .rstn, .clk_en, .in_valid,
    .in_ready, .shift_clk, .ser_data, .latch_load, .blank, .ser_out, .source_on, .sink_on,
    .latch_q);

// ===== dv/sldrv_host.sv
// Host model driving the serial clock and data of the driver core.
// Assumes one core clock; one bit takes three core cycles.
module sldrv_host (
    input wire logic core_clk,
    output logic shift_clk,
    output logic ser_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        shift_clk = 1'b0;
        ser_data = 1'b0;
    end
    // After the hold the line shows the inverse, so stale data cannot pass
    task automatic send(input logic bit_val);
        @(posedge core_clk) #1 ser_data = bit_val;
        @(posedge core_clk) #1 shift_clk = 1'b1;
        @(posedge core_clk) #1 shift_clk = 1'b0;
        ser_data = ~bit_val;
    endtask : send
endmodule : sldrv_host

// ===== dv/sldrv_core_tb.sv
// Testbench of sldrv_core: shifting, latching, blanking, freeze and refusal.
// Assumes the host model drives the serial lines and the bench the rest.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t: value mismatch", $time); end end
module sldrv_core_tb import sldrv_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [SLDRV_STAGES-1:0] PAT_A = 20'hA5C3E, PAT_B = 20'h5F00D;
    localparam logic [SLDRV_STAGES-1:0] PAT_MIX = {PAT_A[SLDRV_STAGES-2:0],
        PAT_B[SLDRV_STAGES-1]};
    logic core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, in_valid = 1'b1;
    logic latch_load = 1'b0, blank = 1'b0, shift_clk, ser_data, in_ready, ser_out;
    logic [SLDRV_STAGES-1:0] source_on, sink_on, latch_q;
    int error_cnt = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    sldrv_host host (.core_clk, .shift_clk, .ser_data);
    sldrv_core uut (.core_clk, .rstn, .clk_en, .in_valid, .in_ready, .shift_clk, .ser_data,
        .latch_load, .blank, .ser_out, .source_on, .sink_on, .latch_q);
    task automatic t_strobe();
        for (int i = SLDRV_STAGES - 1; i >= 0; i--) host.send(PAT_A[i]);
        repeat (3) @(posedge core_clk);
        #1 `CHK(latch_q, SLDRV_ZERO)
        latch_load = 1'b1;
        @(posedge core_clk) #1 latch_load = 1'b0;
        @(posedge core_clk) #1 `CHK(latch_q, PAT_A)
    endtask : t_strobe
    task automatic t_blank();
        @(posedge core_clk) #1 blank = 1'b1;
        @(posedge core_clk) #1 `CHK(sink_on, ~SLDRV_ZERO)
        `CHK(source_on, SLDRV_ZERO)
        blank = 1'b0;
        @(posedge core_clk) #1 `CHK(source_on, PAT_A)
        `CHK(latch_q, PAT_A)
    endtask : t_blank
    task automatic t_transparent();
        blank = 1'b1;
        latch_load = 1'b1;
        host.send(PAT_B[SLDRV_STAGES-1]);
        repeat (2) @(posedge core_clk);
        #1 `CHK(ser_out, PAT_A[SLDRV_STAGES-2])
        `CHK(latch_q, PAT_MIX)
        `CHK(source_on, SLDRV_ZERO)
        for (int i = SLDRV_STAGES - 2; i >= 0; i--) host.send(PAT_B[i]);
        repeat (4) @(posedge core_clk);
        #1 `CHK(latch_q, PAT_B)
        `CHK(ser_out, PAT_B[SLDRV_STAGES-1])
        blank = 1'b0;
    endtask : t_transparent
    task automatic t_refuse();
        clk_en = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 clk_en = 1'b1;
        in_valid = 1'b0;
        host.send(~PAT_B[0]);
        repeat (3) @(posedge core_clk);
        #1 `CHK(latch_q, PAT_B)
        `CHK(ser_out, PAT_B[SLDRV_STAGES-1])
        in_valid = 1'b1;
    endtask : t_refuse
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rstn = 1'b1;
        #1 `CHK(sink_on, ~SLDRV_ZERO)
        `CHK(in_ready, 1'b1)
        t_strobe();
        t_blank();
        t_transparent();
        t_refuse();
        report_and_stop();
    end
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
endmodule : sldrv_core_tb
